/* File: hdl/sgdas_consts.svh */
// Descriptor word offsets, field positions and stream constants
`ifndef SGDAS_CONSTS_SVH
`define SGDAS_CONSTS_SVH
`define SGDAS_W_NXT   4'h0
`define SGDAS_W_BUF   4'h2
`define SGDAS_W_CTL   4'h6
`define SGDAS_W_STS   4'h7
`define SGDAS_W_APP0  4'h8
`define SGDAS_W_USER_APP_WORD_FIVE  4'hc
`define SGDAS_B_CMPLT 31
`define SGDAS_B_SOF   27
`define SGDAS_B_EOF   26
`define SGDAS_CTRL_TAG 4'ha
`define SGDAS_PUSH_LAST 3'h5
`define SGDAS_STS_MAX 3'h5
`endif

/* File: hdl/sgdas_pkg.sv */
// Types shared by the descriptor engine
package sgdas_pkg;
   typedef enum logic [3:0]
   {
      ST_IDLE    = 4'h0,
      ST_FETCH   = 4'h1,
      ST_CHECK   = 4'h2,
      ST_CTRL    = 4'h3,
      ST_XFER    = 4'h4,
      ST_WAITSTS = 4'h5,
      ST_UPDATE  = 4'h6,
      ST_NEXT    = 4'h7,
      ST_PAUSE   = 4'h8,
      ST_HALT    = 4'h9
   } sgdas_state_t;
endpackage

/* File: hdl/sgdas_skid_buf.sv */
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module sgdas_skid_buf #(parameter int W = 33)
(
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         inValid,
   input  wire logic [W-1:0] inData,
   output logic              inReady,
   output logic              outValid,
   output logic [W-1:0]      outData,
   input  wire logic         outReady
);
   logic [W-1:0] mem_q [0:1];  // Entry storage
   logic [W-1:0] mem_d [0:1];
   logic         wp_q, wp_d;   // Write slot
   logic         rp_q, rp_d;   // Read slot
   logic [1:0]   cnt_q, cnt_d; // Words held
   logic         push, pop;

   // Full and empty straight from the count
   assign inReady  = (cnt_q != 2'h2);
   assign outValid = (cnt_q != 2'h0);
   assign outData  = mem_q[rp_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Next pointers and storage
   always_comb
   begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      if (push)
      begin
         mem_d[wp_q] = inData;
         wp_d        = ~wp_q;
      end
      if (pop)
         rp_d = ~rp_q;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   // Registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'h0;
      end
      else
      begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule // sgdas_skid_buf

/* File: hdl/sgdas_core.sv */
// Scatter-gather descriptor engine with control and status sideband streams
//
// Overview of operation
// - Last rx descriptor gets status words
// - Non-last rx descriptors get zeroed user words
// - Sideband off: rx user words never written
// - Length option off: fifth word is status
// - Length option on: fifth word low bits total
// - Walk chain, pause at tail descriptor
// - Tail write while paused resumes fetching
// - Tail write while running just moves tail
// - Tx first descriptor resets realignment engine
// - Tx first descriptor user words go out
// - Later tx user words are ignored
// - Sideband off: user words never fetched
// - Control stream may stall either side
// - Control stream opens with tagged flag word
// - Rx first and last buffers are flagged
// - Each rx descriptor gets its byte count
// - Last rx update waits for whole status
// - Finished descriptor gets completion bit set
// - Stale fetched descriptor halts with error
`timescale 1ns/1ps
`include "sgdas_consts.svh"
module sgdas_core
   import sgdas_pkg::*;
#(parameter int LEN_W = 23)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             runEnable,
   input  wire logic             pathIsRx,
   input  wire logic             sidebandEn,
   input  wire logic             rxLenOpt,
   input  wire logic [31:0]      startPtr,
   input  wire logic             tailWr,
   input  wire logic [31:0]      tailWrData,
   output logic                  paused,
   output logic                  halted,
   output logic                  sgInternalError,
   output logic                  memReq,
   output logic                  memWe,
   output logic [31:0]           memAddr,
   output logic [31:0]           memWdata,
   input  wire logic [31:0]      memRdata,
   input  wire logic             memAck,
   output logic                  xferStart,
   output logic [31:0]           xferAddr,
   output logic [LEN_W-1:0]      xferLen,
   output logic                  xferLast,
   output logic                  realignReset,
   input  wire logic             xferDone,
   input  wire logic [LEN_W-1:0] xferBytes,
   input  wire logic             xferPktEnd,
   output logic                  ctrlValid,
   output logic [31:0]           ctrlData,
   output logic                  ctrlLast,
   input  wire logic             ctrlReady,
   input  wire logic             stsValid,
   input  wire logic [31:0]      stsData,
   input  wire logic             stsLast,
   output logic                  stsReady
);
   sgdas_state_t     st_q, st_d;          // Engine state
   logic [3:0]       wIdx_q, wIdx_d;      // Word within descriptor
   logic [31:0]      cur_q, cur_d;        // Current descriptor
   logic [31:0]      nxt_q, nxt_d;        // Next pointer read
   logic [31:0]      buf_q, buf_d;        // Buffer address read
   logic [31:0]      ctl_q, ctl_d;        // Control word read
   logic [31:0]      sts_q, sts_d;        // Status word read
   logic [31:0]      tail_q, tail_d;      // Tail pointer
   logic [31:0]      app_q [0:4];         // Tx user words
   logic [31:0]      app_d [0:4];
   logic             inPkt_q, inPkt_d;    // Rx packet open
   logic             rxFirst_q, rxFirst_d;
   logic             rxLast_q, rxLast_d;
   logic [LEN_W-1:0] bytes_q, bytes_d;    // Bytes of this buffer
   logic [LEN_W-1:0] total_q, total_d;    // Bytes of whole packet
   logic [2:0]       push_q, push_d;      // Control word index
   logic             req_q, req_d;
   logic             we_q, we_d;
   logic [31:0]      addr_q, addr_d;
   logic [31:0]      wdat_q, wdat_d;
   logic             xs_q, xs_d;
   logic             rr_q, rr_d;
   logic             err_q, err_d;
   logic             fetchApp;            // User words wanted
   logic             pushValid, pushLast, pushReady;
   logic [31:0]      pushData;
   logic [2:0]       appK;
   logic             stsClr;
   // Status capture group
   logic [31:0]      stsW_q [0:4];
   logic [31:0]      stsW_d [0:4];
   logic [2:0]       stsCnt_q, stsCnt_d;
   logic             stsDone_q, stsDone_d;

   // Only a tx packet start with sideband on needs the user words
   assign fetchApp = sidebandEn && !pathIsRx && ctl_q[`SGDAS_B_SOF];

   // Engine next-state logic
   always_comb
   begin
      st_d      = st_q;
      wIdx_d    = wIdx_q;
      cur_d     = cur_q;
      nxt_d     = nxt_q;
      buf_d     = buf_q;
      ctl_d     = ctl_q;
      sts_d     = sts_q;
      app_d     = app_q;
      inPkt_d   = inPkt_q;
      rxFirst_d = rxFirst_q;
      rxLast_d  = rxLast_q;
      bytes_d   = bytes_q;
      total_d   = total_q;
      push_d    = push_q;
      req_d     = req_q;
      we_d      = we_q;
      err_d     = err_q;
      xs_d      = 1'b0;
      rr_d      = 1'b0;
      pushValid = 1'b0;
      pushLast  = 1'b0;
      pushData  = 32'h0;
      stsClr    = 1'b0;
      // A tail write moves the pause point; in ST_PAUSE it also restarts fetching
      tail_d    = tailWr ? tailWrData : tail_q;
      case (st_q)
         ST_IDLE:
            if (runEnable)
            begin
               cur_d  = startPtr;
               wIdx_d = `SGDAS_W_NXT;
               req_d  = 1'b1;
               st_d   = ST_FETCH;
            end
         ST_FETCH:
            if (memAck)
            begin
               case (wIdx_q)
                  `SGDAS_W_NXT: nxt_d = memRdata;
                  `SGDAS_W_BUF: buf_d = memRdata;
                  `SGDAS_W_CTL: ctl_d = memRdata;
                  `SGDAS_W_STS: sts_d = memRdata;
                  default:
                     if (wIdx_q >= `SGDAS_W_APP0)
                        app_d[3'(wIdx_q - `SGDAS_W_APP0)] = memRdata;
               endcase
               // User words are read only for a sideband packet start
               if ((wIdx_q == `SGDAS_W_STS && !fetchApp) || wIdx_q == `SGDAS_W_USER_APP_WORD_FIVE)
               begin
                  req_d = 1'b0;
                  st_d  = ST_CHECK;
               end
               else
                  wIdx_d = wIdx_q + 4'h1;
            end
         ST_CHECK:
            if (sts_q[`SGDAS_B_CMPLT])
            begin
               err_d = 1'b1;
               st_d  = ST_HALT;
            end
            else if (fetchApp)
            begin
               push_d = 3'h0;
               st_d   = ST_CTRL;
            end
            else
            begin
               xs_d      = 1'b1;
               rr_d      = !pathIsRx && ctl_q[`SGDAS_B_SOF];
               rxFirst_d = pathIsRx && !inPkt_q;
               if (!inPkt_q)
                  total_d = '0;
               st_d = ST_XFER;
            end
         ST_CTRL:
         begin
            // Flag word first, then the five user words
            pushValid = 1'b1;
            pushLast  = (push_q == `SGDAS_PUSH_LAST);
            if (push_q == 3'h0)
               pushData = {`SGDAS_CTRL_TAG, 28'h0};
            else
               pushData = app_q[push_q - 3'h1];
            if (pushReady)
            begin
               push_d = push_q + 3'h1;
               if (pushLast)
               begin
                  xs_d = 1'b1;
                  rr_d = 1'b1;
                  st_d = ST_XFER;
               end
            end
         end
         ST_XFER:
            if (xferDone)
            begin
               bytes_d  = xferBytes;
               total_d  = total_q + xferBytes;
               rxLast_d = pathIsRx && xferPktEnd;
               inPkt_d  = pathIsRx && !xferPktEnd;
               if (pathIsRx && xferPktEnd && sidebandEn)
                  st_d = ST_WAITSTS;
               else
               begin
                  wIdx_d = (pathIsRx && sidebandEn) ? `SGDAS_W_APP0 : `SGDAS_W_STS;
                  req_d  = 1'b1;
                  we_d   = 1'b1;
                  st_d   = ST_UPDATE;
               end
            end
         ST_WAITSTS:
            // Last buffer is written back only after the whole status packet
            if (stsDone_q)
            begin
               wIdx_d = `SGDAS_W_APP0;
               req_d  = 1'b1;
               we_d   = 1'b1;
               st_d   = ST_UPDATE;
            end
         ST_UPDATE:
            // User words first, completion word last, so software never
            // sees a completed descriptor with stale user words
            if (memAck)
            begin
               if (wIdx_q == `SGDAS_W_STS)
               begin
                  req_d  = 1'b0;
                  we_d   = 1'b0;
                  stsClr = rxLast_q;
                  st_d   = ST_NEXT;
               end
               else if (wIdx_q == `SGDAS_W_USER_APP_WORD_FIVE)
                  wIdx_d = `SGDAS_W_STS;
               else
                  wIdx_d = wIdx_q + 4'h1;
            end
         ST_NEXT:
            if (cur_q == tail_q)
               st_d = ST_PAUSE;
            else
            begin
               cur_d  = nxt_q;
               wIdx_d = `SGDAS_W_NXT;
               req_d  = 1'b1;
               st_d   = ST_FETCH;
            end
         ST_PAUSE:
            if (tailWr)
            begin
               cur_d  = nxt_q;
               wIdx_d = `SGDAS_W_NXT;
               req_d  = 1'b1;
               st_d   = ST_FETCH;
            end
            else if (!runEnable)
               st_d = ST_IDLE;
         ST_HALT:
            st_d = ST_HALT; // Only reset leaves a halt
         default:
            st_d = ST_IDLE;
      endcase
      // Address and write data follow the word about to be accessed
      addr_d = cur_d + {26'h0, wIdx_d, 2'b00};
      appK   = 3'(wIdx_d - `SGDAS_W_APP0);
      wdat_d = 32'h0;
      if (wIdx_d == `SGDAS_W_STS)
      begin
         wdat_d[`SGDAS_B_CMPLT]   = 1'b1;
         wdat_d[`SGDAS_B_SOF]     = rxFirst_d;
         wdat_d[`SGDAS_B_EOF]     = rxLast_d;
         wdat_d[LEN_W-1:0]        = bytes_d;
      end
      else if (!rxLast_d)
         wdat_d = 32'h0;
      else if (appK == 3'h4 && rxLenOpt)
         wdat_d = {stsW_q[4][31:LEN_W], total_d};
      else if (appK <= 3'h4)
         wdat_d = stsW_q[appK];
   end

   // Engine registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q      <= ST_IDLE;
         wIdx_q    <= 4'h0;
         cur_q     <= 32'h0;
         nxt_q     <= 32'h0;
         buf_q     <= 32'h0;
         ctl_q     <= 32'h0;
         sts_q     <= 32'h0;
         tail_q    <= 32'h0;
         for (int i = 0; i < 5; i++)
            app_q[i] <= 32'h0;
         inPkt_q   <= 1'b0;
         rxFirst_q <= 1'b0;
         rxLast_q  <= 1'b0;
         bytes_q   <= '0;
         total_q   <= '0;
         push_q    <= 3'h0;
         req_q     <= 1'b0;
         we_q      <= 1'b0;
         addr_q    <= 32'h0;
         wdat_q    <= 32'h0;
         xs_q      <= 1'b0;
         rr_q      <= 1'b0;
         err_q     <= 1'b0;
      end
      else
      begin
         st_q      <= st_d;
         wIdx_q    <= wIdx_d;
         cur_q     <= cur_d;
         nxt_q     <= nxt_d;
         buf_q     <= buf_d;
         ctl_q     <= ctl_d;
         sts_q     <= sts_d;
         tail_q    <= tail_d;
         app_q     <= app_d;
         inPkt_q   <= inPkt_d;
         rxFirst_q <= rxFirst_d;
         rxLast_q  <= rxLast_d;
         bytes_q   <= bytes_d;
         total_q   <= total_d;
         push_q    <= push_d;
         req_q     <= req_d;
         we_q      <= we_d;
         addr_q    <= addr_d;
         wdat_q    <= wdat_d;
         xs_q      <= xs_d;
         rr_q      <= rr_d;
         err_q     <= err_d;
      end
   end

   // Status capture: words beyond five are accepted and dropped
   assign stsReady = pathIsRx && sidebandEn && !stsDone_q;
   always_comb
   begin
      stsW_d    = stsW_q;
      stsCnt_d  = stsCnt_q;
      stsDone_d = stsDone_q;
      // Clear fires while done or with sideband off, when no word can be taken
      if (stsClr)
      begin
         stsCnt_d  = 3'h0;
         stsDone_d = 1'b0;
      end
      if (stsValid && stsReady)
      begin
         if (stsCnt_q < `SGDAS_STS_MAX)
         begin
            stsW_d[stsCnt_q] = stsData;
            stsCnt_d         = stsCnt_q + 3'h1;
         end
         if (stsLast)
            stsDone_d = 1'b1;
      end
   end

   // Status registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 5; i++)
            stsW_q[i] <= 32'h0;
         stsCnt_q  <= 3'h0;
         stsDone_q <= 1'b0;
      end
      else
      begin
         stsW_q    <= stsW_d;
         stsCnt_q  <= stsCnt_d;
         stsDone_q <= stsDone_d;
      end
   end

   // Control stream buffer; either side may stall it
   sgdas_skid_buf #(.W(33)) u_ctrlBuf
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .inValid  (pushValid),
      .inData   ({pushLast, pushData}),
      .inReady  (pushReady),
      .outValid (ctrlValid),
      .outData  ({ctrlLast, ctrlData}),
      .outReady (ctrlReady)
   );

   assign paused          = (st_q == ST_PAUSE);
   assign halted          = (st_q == ST_HALT);
   assign sgInternalError = err_q;
   assign memReq          = req_q;
   assign memWe           = we_q;
   assign memAddr         = addr_q;
   assign memWdata        = wdat_q;
   assign xferStart       = xs_q;
   assign xferAddr        = buf_q;
   assign xferLen         = ctl_q[LEN_W-1:0];
   assign xferLast        = ctl_q[`SGDAS_B_EOF];
   assign realignReset    = rr_q;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_stale;
      (st_q == ST_CHECK && sts_q[`SGDAS_B_CMPLT]) |=> halted && sgInternalError;
   endproperty
   a_stale: assert property (p_stale) else $error("stale descriptor not halted");
   property p_pause;
      (st_q == ST_NEXT && cur_q == tail_q) |=> paused;
   endproperty
   a_pause: assert property (p_pause) else $error("no pause at tail");
   property p_resume;
      (paused && tailWr) |=> (memReq && !memWe && memAddr == cur_q);
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after tail write");
   property p_tail;
      (tailWr && !paused) |=> tail_q == $past(tailWrData);
   endproperty
   a_tail: assert property (p_tail) else $error("tail not moved");
   property p_cmplt;
      (memReq && memWe && memAddr[5:2] == `SGDAS_W_STS) |-> memWdata[`SGDAS_B_CMPLT];
   endproperty
   a_cmplt: assert property (p_cmplt) else $error("completion bit missing");
   property p_zero;
      (memReq && memWe && memAddr[5:2] >= `SGDAS_W_APP0 && !rxLast_q) |-> memWdata == 32'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("user word not zeroed");
   property p_noapp;
      (memReq && !sidebandEn) |-> memAddr[5:2] < `SGDAS_W_APP0;
   endproperty
   a_noapp: assert property (p_noapp) else $error("user word touched with sideband off");
   property p_tag;
      (pushValid && push_q == 3'h0) |-> pushData[31:28] == `SGDAS_CTRL_TAG;
   endproperty
   a_tag: assert property (p_tag) else $error("bad control flag word");
   property p_wait;
      (st_q == ST_UPDATE && rxLast_q && sidebandEn) |-> stsDone_q;
   endproperty
   a_wait: assert property (p_wait) else $error("last update before status");
   c_pause: cover property (paused ##[1:50] tailWr);
   c_ctrl: cover property (ctrlValid && ctrlLast && ctrlReady);
   c_rxlast: cover property (st_q == ST_WAITSTS ##[1:100] st_q == ST_UPDATE);
endmodule // sgdas_core

/* File: tb/sgdas_periph.sv */
// Streaming peripheral model: takes control words, returns status words
`timescale 1ns/1ps
module sgdas_periph
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ctrlValid,
   input  wire logic [31:0] ctrlData,
   input  wire logic        ctrlLast,
   output logic             ctrlReady,
   input  wire logic        stsGo,
   input  wire logic [31:0] stsBase,
   output logic             stsValid,
   output logic [31:0]      stsData,
   output logic             stsLast,
   input  wire logic        stsReady
);
   logic [31:0] ctrlWords [0:15]; // Control words in arrival order
   int          ctrlCnt;          // Control words taken
   int          ctrlLastIdx;      // Index of the word marked last
   int          stsLeft;          // Status beats still owed
   time         stsT;             // When the final status beat left
   logic        took;             // Status beat taken at this edge

   initial
   begin
      ctrlReady = 1'h0;
      stsValid  = 1'h0;
      stsLast   = 1'h0;
      stsData   = 32'h0;
   end

   // Random stalls on both streams; an idle status line inverts its data every cycle
   always @(posedge clk_sys)
   begin
      took = stsValid && stsReady;
      if (!rst_n)
         stsLeft = 0;
      else
      begin
         if (ctrlValid && ctrlReady)
         begin
            ctrlWords[ctrlCnt[3:0]] = ctrlData;
            if (ctrlLast)
               ctrlLastIdx = ctrlCnt;
            ctrlCnt++;
         end
         if (took && stsLast)
            stsT = $time;
         if (took)
            stsLeft--;
         if (stsGo)
            stsLeft = 5;
      end
      if (!rst_n)
         ctrlCnt = 0;
      #1;
      ctrlReady = ($urandom % 4 != 0);
      // A beat on offer is held until it is taken
      if (!rst_n || took || !stsValid)
      begin
         if (rst_n && stsLeft > 0 && $urandom % 3 != 0)
         begin
            stsValid = 1'h1;
            stsData  = stsBase + 32'(5 - stsLeft);
            stsLast  = (stsLeft == 1);
         end
         else
         begin
            stsValid = 1'h0;
            stsLast  = 1'h0;
            stsData  = ~stsData;
         end
      end
   end
endmodule // sgdas_periph

/* File: tb/tb_sgdas_core.sv */
// Self-checking bench for the scatter-gather descriptor engine
`timescale 1ns/1ps
module tb_sgdas_core;
   localparam int LW = 23;
   logic          clk_sys, rst_n, runEnable, pathIsRx, sidebandEn, rxLenOpt, tailWr, stsGo, usrRd;
   logic          paused, halted, sgInternalError, memReq, memWe, memAck, xferStart, xferLast;
   logic          realignReset, xferDone, xferPktEnd, ctrlValid, ctrlLast, ctrlReady, stsValid, stsLast, stsReady;
   logic [31:0]   startPtr, tailWrData, memAddr, memWdata, memRdata, xferAddr, ctrlData, stsData, stsBase;
   logic [LW-1:0] xferLen, xferBytes, tot;
   logic [31:0]   mem [0:255];  // Descriptor memory, 16 words per descriptor
   logic [31:0]   orig [0:255]; // Memory as it stood before the run
   int            miscompares, compares, nStart, nRealign, xCnt, i, j;
   time           w7T;          // When the last receive status word landed

   sgdas_core #(.LEN_W(LW)) u_dut
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .runEnable(runEnable), .pathIsRx(pathIsRx),
      .sidebandEn(sidebandEn), .rxLenOpt(rxLenOpt), .startPtr(startPtr), .tailWr(tailWr),
      .tailWrData(tailWrData), .paused(paused), .halted(halted), .sgInternalError(sgInternalError),
      .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
      .memAck(memAck), .xferStart(xferStart), .xferAddr(xferAddr), .xferLen(xferLen), .xferLast(xferLast),
      .realignReset(realignReset), .xferDone(xferDone), .xferBytes(xferBytes), .xferPktEnd(xferPktEnd),
      .ctrlValid(ctrlValid), .ctrlData(ctrlData), .ctrlLast(ctrlLast), .ctrlReady(ctrlReady),
      .stsValid(stsValid), .stsData(stsData), .stsLast(stsLast), .stsReady(stsReady)
   );

   sgdas_periph u_peer
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .ctrlValid(ctrlValid), .ctrlData(ctrlData), .ctrlLast(ctrlLast),
      .ctrlReady(ctrlReady), .stsGo(stsGo), .stsBase(stsBase), .stsValid(stsValid), .stsData(stsData),
      .stsLast(stsLast), .stsReady(stsReady)
   );

   initial
   begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Memory answers after a random wait; read data is scrambled when idle
   always @(posedge clk_sys)
   begin
      if (memReq && memAck && memWe)
      begin
         mem[memAddr[9:2]] = memWdata;
         if (memAddr[5:2] == 4'h7 && memWdata[26])
            w7T = $time;
      end
      if (memReq && memAck && !memWe && memAddr[5:2] >= 4'h8)
         usrRd = 1'h1;
      #1;
      memAck   = memReq && ($urandom % 3 != 0);
      memRdata = memAck ? mem[memAddr[9:2]] : ~memRdata;
   end

   // Data mover: each transfer ends three cycles after it starts
   always @(posedge clk_sys)
   begin
      #1;
      // Buffers are taken in chain order, so the start count names the descriptor
      if (xferStart)
      begin
         xferDone = 1'h0;
         nStart++;
         chk(xferAddr, orig[(nStart - 1) * 16 + 2]);
         if (realignReset)
            nRealign++;
         xCnt = 3;
      end
      else
      begin
         xferDone = (xCnt == 1);
         if (xCnt > 0)
         begin
            xCnt--;
            xferPktEnd = xferLast;
            xferBytes  = xferLen - (xferLast ? 23'h3 : 23'h0);
         end
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cyc();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic tailPulse(input int idx);
      tailWr     = 1'h1;
      tailWrData = 32'(idx * 64);
      cyc();
      tailWr = 1'h0;
   endtask

   // Bounded wait for a pause at the tail or a halt
   task automatic waitStop();
      for (int k = 0; k < 3000 && paused !== 1'h1 && halted !== 1'h1; k++)
         cyc();
      chk(32'(paused | halted), 32'h1);
   endtask

   // Software builds the whole chain before starting
   task automatic runChain(input logic rx, sb, lo, late, st, input int n, tl, mv, input logic [3:0] fm, lm);
      rst_n      = 1'h0;
      runEnable  = 1'h0;
      pathIsRx   = rx;
      sidebandEn = sb;
      rxLenOpt   = lo;
      nStart     = 0;
      nRealign   = 0;
      xCnt       = 0;
      usrRd      = 1'h0;
      stsBase    = $urandom;
      for (int k = 0; k < 256; k++)
         mem[k] = $urandom;
      for (int k = 0; k < n; k++)
      begin
         mem[k*16]   = 32'((k + 1) * 64);
         mem[k*16+6] = {4'h0, fm[k], lm[k], 3'h0, 23'(8 + $urandom % 64)};
         mem[k*16+7] = {st, 31'h0};
      end
      orig = mem;
      repeat (4) cyc();
      rst_n = 1'h1;
      cyc();
      tailPulse(tl);
      runEnable = 1'h1;
      // Status early in the frame, or after the data when allowed
      if (rx && sb)
         fork
            begin
               if (late)
                  wait (xferDone === 1'h1 && xferPktEnd === 1'h1);
               cyc();
               stsGo = 1'h1;
               cyc();
               stsGo = 1'h0;
            end
         join_none
      if (mv > 0)
      begin
         repeat (3) cyc();
         tailPulse(mv);
      end
      waitStop();
   endtask

   // Status word expected in a user word; the fifth may carry the total
   function automatic logic [31:0] stsExp(input int k, input logic lo, input logic [LW-1:0] t);
      logic [31:0] s;
      s = stsBase + 32'(k);
      return (k == 4 && lo) ? {s[31:LW], t} : s;
   endfunction

   initial
   begin
      {rst_n, runEnable, pathIsRx, sidebandEn, rxLenOpt, tailWr, memAck, xferDone, xferPktEnd, stsGo} = 10'h0;
      startPtr    = 32'h0;
      tailWrData  = 32'h0;
      memRdata    = 32'h0;
      xferBytes   = 23'h0;
      stsBase     = 32'h0;
      miscompares = 0;
      compares    = 0;
      void'($urandom(27543));
      // Transmit with sideband: two packets, pause at tail, then resume
      runChain(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3, 1, 0, 4'h5, 4'h6);
      chk(32'(mem[39][31]), 32'h0);
      chk(32'(mem[23][31]), 32'h1);
      chk(32'(nRealign), 32'h1);
      chk(32'(u_peer.ctrlCnt), 32'h6);
      chk(32'(u_peer.ctrlLastIdx), 32'h5);
      tailPulse(2);
      repeat (2) cyc();
      waitStop();
      chk(32'(mem[39][31]), 32'h1);
      chk(32'(nRealign), 32'h2);
      chk(32'(u_peer.ctrlCnt), 32'hc);
      for (i = 0; i < 2; i++)
      begin
         chk(32'(u_peer.ctrlWords[i*6][31:28]), 32'ha);
         for (j = 0; j < 5; j++)
            chk(u_peer.ctrlWords[i*6+j+1], orig[i*32+8+j]);
      end
      // Transmit without sideband, tail moved while running
      runChain(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3, 0, 2, 4'h1, 4'h4);
      chk(32'(mem[39][31]), 32'h1);
      chk(32'(nStart), 32'h3);
      chk(32'(usrRd), 32'h0);
      chk(32'(u_peer.ctrlCnt), 32'h0);
      // Receive with sideband and length option over three buffers
      runChain(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 3, 2, 0, 4'h1, 4'h4);
      tot = 23'h0;
      for (i = 0; i < 3; i++)
      begin
         tot += orig[i*16+6][LW-1:0];
         chk(mem[i*16+7], {1'h1, 3'h0, i == 0, i == 2, 3'h0, orig[i*16+6][LW-1:0] - (i == 2 ? 23'h3 : 23'h0)});
      end
      tot -= 23'h3;
      for (j = 0; j < 5; j++)
      begin
         chk(mem[8+j] | mem[24+j], 32'h0);
         chk(mem[40+j], stsExp(j, 1'h1, tot));
      end
      // Receive, length option off, status arriving after the data
      runChain(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1, 0, 0, 4'h1, 4'h1);
      chk(mem[12], stsExp(4, 1'h0, tot));
      chk(32'(w7T > u_peer.stsT), 32'h1);
      // Receive without sideband: user words left alone
      runChain(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1, 0, 0, 4'h1, 4'h1);
      for (j = 0; j < 5; j++)
         chk(mem[8+j], orig[8+j]);
      // Descriptor already marked complete is stale
      runChain(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1, 0, 0, 4'h1, 4'h1);
      chk(32'(sgInternalError & halted), 32'h1);
      chk(32'(nStart), 32'h0);
      results();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #1500000;
      miscompares++;
      results();
   end
endmodule // tb_sgdas_core
